// [hw/grip_pkg.sv]
// constants, field layouts and state codes of the gripper register bank
// How it works
// - controller writes the output region; every defined byte is stored and used.
// - input region mirrors gripper state; controller only reads it.
// - both regions are sixteen bytes, indexed 0 to 15.
// - output bytes: 0 action, 3 target, 4 speed, 5 force, rest reserved.
// - input bytes: 0 status, 2 fault, 3 echo, 4 position, 5 current.
// - action byte: bit0 activate, bit3 go-to, bit4 auto release, bit5 direction.
// - activate must be one first; activation starts when it becomes one.
// - activate at zero puts gripper in reset and clears fault status.
// - both fingers move together, started only by the single go-to command.
// - after go-to starts, object detection reports whether something was picked.
// - emergency auto release with selectable opening or closing direction.
// - all commands and status travel over one serial link.
// - go-to one moves to target with speed and force; zero stops.
// - auto release overrides every command except activate.
// - direction zero closes, one opens; sampled when the release starts.
package grip_pkg;
	localparam int ADDR_W = 4;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] OUT_ACTION = 4'h0;
	localparam logic [3:0] OUT_TARGET = 4'h3;
	localparam logic [3:0] OUT_SPEED = 4'h4;
	localparam logic [3:0] OUT_FORCE = 4'h5;
	localparam logic [3:0] IN_STATUS = 4'h0;
	localparam logic [3:0] IN_FAULT = 4'h2;
	localparam logic [3:0] IN_ECHO = 4'h3;
	localparam logic [3:0] IN_POS = 4'h4;
	localparam logic [3:0] IN_CURRENT = 4'h5;
	localparam int ACT_BIT = 0;
	localparam int GTO_BIT = 3;
	localparam int ATR_BIT = 4;
	localparam int ARD_BIT = 5;
	localparam logic [1:0] STA_RESET = 2'h0;
	localparam logic [1:0] STA_ACTIVATING = 2'h1;
	localparam logic [1:0] STA_DONE = 2'h3;
	localparam logic [1:0] OBJ_MOVING = 2'h0;
	localparam logic [1:0] OBJ_OPENING = 2'h1;
	localparam logic [1:0] OBJ_CLOSING = 2'h2;
	localparam logic [1:0] OBJ_AT_TARGET = 2'h3;
	localparam logic [3:0] FLT_NONE = 4'h0;
	localparam logic [3:0] FLT_DELAYED = 4'h5;
	localparam logic [3:0] FLT_NOT_ACT = 4'h7;
	localparam logic [3:0] FLT_OVERTEMP = 4'h8;
	localparam logic [3:0] FLT_NO_COMM = 4'h9;
	localparam logic [3:0] FLT_UNDERVOLT = 4'hA;
	localparam logic [3:0] FLT_REL_BUSY = 4'hB;
	localparam logic [3:0] FLT_OVERCUR = 4'hE;
	localparam logic [3:0] FLT_REL_DONE = 4'hF;
	localparam logic [3:0] FLT_MAJOR_MIN = 4'hA;
	typedef enum logic [4:0] {
		ST_RESET = 5'h01,
		ST_ACTIVATING = 5'h02,
		ST_READY = 5'h04,
		ST_RELEASING = 5'h08,
		ST_RELEASED = 5'h10
	} grip_state_t;
endpackage

// [hw/input_region_mux.sv]
// read multiplexer of the sixteen-byte input region
`timescale 1ns/1ps
`default_nettype none
module input_region_mux (
	input wire logic [grip_pkg::ADDR_W-1:0] addr,
	input wire logic [1:0] obj_status,
	input wire logic [1:0] run_status,
	input wire logic goto_echo,
	input wire logic act_echo,
	input wire logic [3:0] fault_code,
	input wire logic [7:0] target_echo,
	input wire logic [7:0] pos_now,
	input wire logic [7:0] current_now,
	output logic [7:0] byte_out
);
	import grip_pkg::*;
	always_comb begin
		byte_out = BYTE_ZERO; // reserved bytes and bits stay zero
		case (addr)
			IN_STATUS: begin
				byte_out = {obj_status, run_status, goto_echo, 2'b00, act_echo};
			end
			IN_FAULT: begin
				byte_out = {4'h0, fault_code};
			end
			IN_ECHO: begin
				byte_out = target_echo;
			end
			IN_POS: begin
				byte_out = pos_now;
			end
			IN_CURRENT: begin
				byte_out = current_now;
			end
			default: begin
				byte_out = BYTE_ZERO;
			end
		endcase
	end
endmodule // input_region_mux
`default_nettype wire

// [hw/obj_detector.sv]
// object detection status tracking for go-to motions
`timescale 1ns/1ps
`default_nettype none
module obj_detector (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic goto_active,
	input wire logic [7:0] target,
	input wire logic [7:0] pos_now,
	input wire logic contact,
	input wire logic move_done,
	output logic [1:0] obj_status
);
	import grip_pkg::*;
	logic [1:0] obj_r, obj_nxt;
	logic go_d_r, go_d_nxt;
	logic closing_r, closing_nxt;
	logic [7:0] tgt_d_r, tgt_d_nxt;
	logic start;
	always_comb begin
		go_d_nxt = goto_active;
		tgt_d_nxt = target;
		obj_nxt = obj_r;
		closing_nxt = closing_r;
		start = goto_active && (!go_d_r || target != tgt_d_r);
		if (start) begin
			obj_nxt = OBJ_MOVING; // new motion, nothing detected yet
			closing_nxt = target > pos_now;
		end else if (goto_active && obj_r == OBJ_MOVING) begin
			if (contact) begin
				obj_nxt = closing_r ? OBJ_CLOSING : OBJ_OPENING;
			end else if (move_done) begin
				obj_nxt = OBJ_AT_TARGET;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			obj_r <= OBJ_MOVING;
			go_d_r <= 1'b0;
			closing_r <= 1'b0;
			tgt_d_r <= BYTE_ZERO;
		end else begin
			obj_r <= obj_nxt;
			go_d_r <= go_d_nxt;
			closing_r <= closing_nxt;
			tgt_d_r <= tgt_d_nxt;
		end
	end
	assign obj_status = obj_r;
	property p_contact_seen;
		@(posedge clk_sys) disable iff (rst)
		goto_active && go_d_r && target == tgt_d_r && obj_r == OBJ_MOVING && contact
		|=> obj_r == (closing_r ? OBJ_CLOSING : OBJ_OPENING);
	endproperty
	a_contact_detect: assert property (p_contact_seen)
		else $error("contact did not yield an object detection code");
endmodule // obj_detector
`default_nettype wire

// [hw/gripper_command_status_registers.sv]
// gripper output/input register regions with activation, go-to and release control
`timescale 1ns/1ps
`default_nettype none
module gripper_command_status_registers (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [grip_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [grip_pkg::ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic calib_done,
	input wire logic release_done,
	input wire logic move_done,
	input wire logic contact,
	input wire logic [7:0] pos_actual,
	input wire logic [7:0] current_actual,
	input wire logic overcurrent,
	input wire logic undervoltage,
	input wire logic overtemp,
	input wire logic comm_timeout,
	output logic calib_start,
	output logic motion_go,
	output logic [7:0] motion_target,
	output logic [7:0] motion_speed,
	output logic [7:0] motion_force,
	output logic release_active,
	output logic release_open
);
	import grip_pkg::*;

	// output region storage
	logic [7:0] action_r, action_nxt;
	logic [7:0] target_r, target_nxt;
	logic [7:0] speed_r, speed_nxt;
	logic [7:0] force_r, force_nxt;

	// control state
	grip_state_t state_r, state_nxt;
	logic [3:0] fault_r, fault_nxt;
	logic rel_open_r, rel_open_nxt;
	logic go_r, go_nxt;
	logic calib_r, calib_nxt;
	logic rel_act_r, rel_act_nxt;
	logic [3:0] live_fault;
	logic act, gto, atr, ard, major;

	// read port
	logic [7:0] rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [7:0] mux_byte;
	logic [1:0] obj_status;
	logic [1:0] run_status;

	assign act = action_r[ACT_BIT];
	assign gto = action_r[GTO_BIT];
	assign atr = action_r[ATR_BIT];
	assign ard = action_r[ARD_BIT];
	assign major = fault_r >= FLT_MAJOR_MIN;

	// register writes arriving from the serial link's frame decoder
	always_comb begin
		action_nxt = action_r;
		target_nxt = target_r;
		speed_nxt = speed_r;
		force_nxt = force_r;
		if (wr_en) begin
			case (wr_addr)
				OUT_ACTION: begin
					action_nxt = wr_data;
				end
				OUT_TARGET: begin
					target_nxt = wr_data;
				end
				OUT_SPEED: begin
					speed_nxt = wr_data;
				end
				OUT_FORCE: begin
					force_nxt = wr_data;
				end
				default: begin
					action_nxt = action_r; // reserved bytes are not stored
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			action_r <= BYTE_ZERO;
			target_r <= BYTE_ZERO;
			speed_r <= BYTE_ZERO;
			force_r <= BYTE_ZERO;
		end else begin
			action_r <= action_nxt;
			target_r <= target_nxt;
			speed_r <= speed_nxt;
			force_r <= force_nxt;
		end
	end

	// faults that follow their cause while no major fault is latched
	always_comb begin
		live_fault = FLT_NONE;
		if (act && overcurrent) begin
			live_fault = FLT_OVERCUR;
		end else if (act && undervoltage) begin
			live_fault = FLT_UNDERVOLT;
		end else if (act && overtemp) begin
			live_fault = FLT_OVERTEMP;
		end else if (act && comm_timeout) begin
			live_fault = FLT_NO_COMM;
		end else if (gto && !act) begin
			live_fault = FLT_NOT_ACT;
		end else if (gto && state_r == ST_ACTIVATING) begin
			live_fault = FLT_DELAYED;
		end
	end

	// activation, go-to and auto release sequencing
	always_comb begin
		state_nxt = state_r;
		fault_nxt = fault_r;
		rel_open_nxt = rel_open_r;
		case (state_r)
			ST_RESET: begin
				if (act) begin
					state_nxt = ST_ACTIVATING;
				end
			end
			ST_ACTIVATING: begin
				if (atr) begin
					state_nxt = ST_RELEASING;
				end else if (calib_done) begin
					state_nxt = ST_READY;
				end
			end
			ST_READY: begin
				if (atr) begin
					state_nxt = ST_RELEASING;
				end
			end
			ST_RELEASING: begin
				if (release_done) begin
					state_nxt = ST_RELEASED;
				end
			end
			ST_RELEASED: begin
				state_nxt = ST_RELEASED;
			end
			default: begin
				state_nxt = ST_RESET;
			end
		endcase
		if (!act) begin
			state_nxt = ST_RESET; // activate low forces reset
		end
		if (state_nxt == ST_RELEASING && state_r != ST_RELEASING) begin
			rel_open_nxt = ard; // direction caught at release start
		end
		// clear first, any cause set afterwards wins
		if (!act || !major) begin
			fault_nxt = FLT_NONE;
		end
		if (state_nxt == ST_RELEASED) begin
			fault_nxt = FLT_REL_DONE;
		end else if (state_nxt == ST_RELEASING) begin
			fault_nxt = FLT_REL_BUSY;
		end else if (live_fault != FLT_NONE && !(major && act)) begin
			fault_nxt = live_fault;
		end
	end

	always_comb begin
		go_nxt = state_nxt == ST_READY && gto && !major; // both fingers, one command
		calib_nxt = state_nxt == ST_ACTIVATING;
		rel_act_nxt = state_nxt == ST_RELEASING;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ST_RESET;
			fault_r <= FLT_NONE;
			rel_open_r <= 1'b0;
			go_r <= 1'b0;
			calib_r <= 1'b0;
			rel_act_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			fault_r <= fault_nxt;
			rel_open_r <= rel_open_nxt;
			go_r <= go_nxt;
			calib_r <= calib_nxt;
			rel_act_r <= rel_act_nxt;
		end
	end

	obj_detector u_obj (
		.clk_sys(clk_sys),
		.rst(rst),
		.goto_active(go_r),
		.target(target_r),
		.pos_now(pos_actual),
		.contact(contact),
		.move_done(move_done),
		.obj_status(obj_status)
	);

	always_comb begin
		case (state_r)
			ST_ACTIVATING: run_status = STA_ACTIVATING;
			ST_READY: run_status = STA_DONE;
			default: run_status = STA_RESET;
		endcase
	end

	input_region_mux u_mux (
		.addr(rd_addr),
		.obj_status(obj_status),
		.run_status(run_status),
		.goto_echo(gto),
		.act_echo(act),
		.fault_code(fault_r),
		.target_echo(target_r),
		.pos_now(pos_actual),
		.current_now(current_actual),
		.byte_out(mux_byte)
	);

	// reads of the input region, one cycle after the request
	always_comb begin
		rd_valid_nxt = rd_en;
		rd_data_nxt = rd_en ? mux_byte : rd_data_r;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_data_r <= BYTE_ZERO;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;
	assign calib_start = calib_r;
	assign motion_go = go_r;
	assign motion_target = target_r;
	assign motion_speed = speed_r;
	assign motion_force = force_r;
	assign release_active = rel_act_r;
	assign release_open = rel_open_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_act_off_write;
		wr_en && wr_addr == OUT_ACTION && !wr_data[ACT_BIT] && !wr_data[GTO_BIT];
	endsequence
	sequence s_release_request;
		act && atr && (state_r == ST_ACTIVATING || state_r == ST_READY);
	endsequence

	a_act_low_reset: assert property (!act |=> state_r == ST_RESET && !motion_go)
		else $error("activate low did not hold the gripper in reset");
	a_fault_cleared: assert property (s_act_off_write |-> ##2 fault_r == FLT_NONE)
		else $error("fault status not cleared by activate low");
	a_act_starts: assert property (state_r == ST_RESET && act |=> calib_start)
		else $error("activation routine did not start");
	a_release_wins: assert property (s_release_request |=> release_active && !motion_go)
		else $error("auto release did not override other commands");
	a_release_dir: assert property ($rose(release_active) |-> release_open == $past(ard))
		else $error("release direction not sampled at release start");
	a_release_fault: assert property (release_active |-> fault_r == FLT_REL_BUSY)
		else $error("release in progress not reported");
	a_goto_moves: assert property (state_r == ST_READY && act && gto && !atr && !major
		|=> motion_go)
		else $error("go-to did not start motion");
	a_goto_stops: assert property (!gto |=> !motion_go)
		else $error("motion continued with go-to low");
	a_target_store: assert property (wr_en && wr_addr == OUT_TARGET
		|=> motion_target == $past(wr_data))
		else $error("target position write not stored");
	a_reserved_zero: assert property (rd_en && rd_addr == 4'h1
		|=> rd_valid && rd_data == BYTE_ZERO)
		else $error("reserved input byte did not read zero");
	a_echo_read: assert property (rd_en && rd_addr == IN_ECHO
		|=> rd_data == $past(target_r))
		else $error("target echo read mismatch");

	sequence s_release_finished;
		act && state_r == ST_RELEASED;
	endsequence

	a_not_act_fault: assert property (gto && !act |=> fault_r == FLT_NOT_ACT)
		else $error("go-to without activate not reported");
	a_release_no_go: assert property (release_active |-> !motion_go)
		else $error("motion commanded during auto release");
	a_reserved_high: assert property (rd_en && rd_addr > IN_CURRENT
		|=> rd_data == BYTE_ZERO)
		else $error("reserved upper input byte did not read zero");
	a_release_latched: assert property (s_release_finished
		|=> fault_r == FLT_REL_DONE)
		else $error("release completion not held until reactivation");
endmodule // gripper_command_status_registers
`default_nettype wire

// [sim/mech_model.sv]
// behavioural finger mechanism answering the motion-side outputs of the register bank
`timescale 1ns/1ps
`default_nettype none
module mech_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic calib_start,
	input wire logic motion_go,
	input wire logic [7:0] motion_target,
	input wire logic release_active,
	input wire logic [7:0] stop_at,
	output logic calib_done,
	output logic release_done,
	output logic move_done,
	output logic contact,
	output logic [7:0] pos_actual
);
	logic [4:0] cal_cnt_r;
	logic [4:0] rel_cnt_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cal_cnt_r <= 5'h00;
			rel_cnt_r <= 5'h00;
			pos_actual <= 8'h00;
		end else begin
			cal_cnt_r <= !calib_start ? 5'h00 : (cal_cnt_r == 5'h1F ? cal_cnt_r : cal_cnt_r + 5'h01);
			rel_cnt_r <= !release_active ? 5'h00 : (rel_cnt_r == 5'h1F ? rel_cnt_r : rel_cnt_r + 5'h01);
			// one shared position: both fingers step together, only under motion_go
			if (motion_go && !contact && pos_actual != motion_target) begin
				pos_actual <= pos_actual < motion_target ? pos_actual + 8'h01 : pos_actual - 8'h01;
			end
		end
	end
	assign calib_done = cal_cnt_r == 5'h10;
	assign release_done = rel_cnt_r == 5'h10;
	assign move_done = motion_go && pos_actual == motion_target;
	// a nonzero stop_at places an object in the fingers' path
	assign contact = motion_go && stop_at != 8'h00 && pos_actual == stop_at;
endmodule // mech_model
`default_nettype wire

// [sim/gripper_command_status_registers_tb_top.sv]
// self-checking bench of the gripper register bank with a mechanism model
`timescale 1ns/1ps
`default_nettype none
module gripper_command_status_registers_tb_top;
	import grip_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic wr_en = 1'b0;
	logic [3:0] wr_addr = 4'h0;
	logic [7:0] wr_data = 8'h00;
	logic rd_en = 1'b0;
	logic [3:0] rd_addr = 4'h0;
	logic [7:0] cur = 8'h5A;
	logic [3:0] flt_in = 4'h0;
	logic [7:0] stop_at = 8'h00;
	logic [7:0] rd_data, pos_actual, motion_target, motion_speed, motion_force;
	logic rd_valid, calib_done, release_done, move_done, contact;
	logic calib_start, motion_go, release_active, release_open;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic [3:0] fcode [4] = '{FLT_OVERTEMP, FLT_NO_COMM, FLT_UNDERVOLT, FLT_OVERCUR};
	gripper_command_status_registers DUT (.clk_sys(clk_sys), .rst(rst), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data(rd_data), .rd_valid(rd_valid), .calib_done(calib_done),
		.release_done(release_done), .move_done(move_done), .contact(contact),
		.pos_actual(pos_actual), .current_actual(cur), .overcurrent(flt_in[3]),
		.undervoltage(flt_in[2]), .overtemp(flt_in[0]), .comm_timeout(flt_in[1]),
		.calib_start(calib_start), .motion_go(motion_go), .motion_target(motion_target),
		.motion_speed(motion_speed), .motion_force(motion_force),
		.release_active(release_active), .release_open(release_open));
	mech_model mech (.clk_sys(clk_sys), .rst(rst), .calib_start(calib_start),
		.motion_go(motion_go), .motion_target(motion_target), .release_active(release_active),
		.stop_at(stop_at), .calib_done(calib_done), .release_done(release_done),
		.move_done(move_done), .contact(contact), .pos_actual(pos_actual));
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// every access starts and ends at a falling edge, with one idle edge after it
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge clk_sys);
		wr_en = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		rd_en = 1'b1;
		rd_addr = a;
		@(negedge clk_sys);
		d = rd_data;
		chk("rd_valid", 8'h01, {7'h00, rd_valid});
		rd_en = 1'b0;
		@(negedge clk_sys);
	endtask
	// reads until the masked byte matches or the bound runs out, then compares
	task automatic poll(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] d;
		for (int i = 0; i < 100; i++) begin
			rd(a, d);
			if ((d & m) === e) break;
		end
		chk("input_byte", e, d & m);
	endtask
	task automatic nc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic done(input string n);
		$display("test %s done, errors so far %0d", n, num_errors);
	endtask
	initial begin
		logic [7:0] d;
		nc(5);
		rst = 1'b0;
		for (int a = 0; a < 16; a++) begin
			rd(a[3:0], d);
			chk("reset_byte", a == 5 ? cur : 8'h00, d);
		end
		chk("go_reset", 8'h00, {7'h00, motion_go});
		done("reset_values");
		wr(OUT_TARGET, 8'h40);
		wr(OUT_SPEED, 8'h80);
		wr(OUT_FORCE, 8'hC0);
		wr(4'h1, 8'hFF);
		wr(4'h2, 8'hFF);
		for (int a = 6; a < 16; a++) wr(a[3:0], 8'h00);
		chk("target", 8'h40, motion_target);
		chk("speed", 8'h80, motion_speed);
		chk("force", 8'hC0, motion_force);
		poll(IN_ECHO, 8'h40, 8'hFF);
		poll(4'h1, 8'h00, 8'hFF);
		done("output_region");
		wr(OUT_ACTION, 8'h08);
		poll(IN_FAULT, {4'h0, FLT_NOT_ACT}, 8'hFF);
		poll(IN_STATUS, 8'h08, 8'h39);
		chk("go_inactive", 8'h00, {7'h00, motion_go});
		done("goto_unactivated");
		wr(OUT_ACTION, 8'h01);
		chk("calib_start", 8'h01, {7'h00, calib_start});
		poll(IN_STATUS, {2'h0, STA_ACTIVATING, 4'h1}, 8'h31);
		wr(OUT_ACTION, 8'h09);
		poll(IN_FAULT, {4'h0, FLT_DELAYED}, 8'hFF);
		poll(IN_STATUS, {OBJ_AT_TARGET, STA_DONE, 4'h9}, 8'hFF);
		chk("go_ready", 8'h01, {7'h00, motion_go});
		poll(IN_POS, 8'h40, 8'hFF);
		poll(IN_FAULT, 8'h00, 8'hFF);
		done("activate_goto");
		stop_at = 8'h80;
		wr(OUT_TARGET, 8'hC0);
		poll(IN_STATUS, {OBJ_CLOSING, 6'h00}, 8'hC0);
		stop_at = 8'h30;
		wr(OUT_TARGET, 8'h10);
		poll(IN_STATUS, {OBJ_OPENING, 6'h00}, 8'hC0);
		// the object stays in place until go-to has dropped, so the fingers cannot creep on
		wr(OUT_ACTION, 8'h01);
		nc(3);
		stop_at = 8'h00;
		chk("go_stop", 8'h00, {7'h00, motion_go});
		poll(IN_POS, 8'h30, 8'hFF);
		done("object_detection");
		for (int i = 0; i < 4; i++) begin
			flt_in = 4'h1 << i;
			poll(IN_FAULT, {4'h0, fcode[i]}, 8'hFF);
			flt_in = 4'h0;
			nc(4);
			if (fcode[i] >= FLT_MAJOR_MIN) begin
				poll(IN_FAULT, {4'h0, fcode[i]}, 8'hFF);
				wr(OUT_ACTION, 8'h00);
				poll(IN_FAULT, 8'h00, 8'hFF);
				wr(OUT_ACTION, 8'h01);
				poll(IN_STATUS, {2'h0, STA_DONE, 4'h1}, 8'h31);
			end
			poll(IN_FAULT, 8'h00, 8'hFF);
		end
		done("fault_codes");
		wr(OUT_ACTION, 8'h11);
		poll(IN_FAULT, {4'h0, FLT_REL_BUSY}, 8'hFF);
		chk("rel_active", 8'h01, {7'h00, release_active});
		chk("rel_close", 8'h00, {7'h00, release_open});
		wr(OUT_ACTION, 8'h39);
		nc(2);
		chk("rel_sampled", 8'h00, {7'h00, release_open});
		chk("go_override", 8'h00, {7'h00, motion_go});
		poll(IN_FAULT, {4'h0, FLT_REL_DONE}, 8'hFF);
		chk("rel_end", 8'h00, {7'h00, release_active});
		wr(OUT_ACTION, 8'h09);
		poll(IN_FAULT, {4'h0, FLT_REL_DONE}, 8'hFF);
		wr(OUT_ACTION, 8'h00);
		poll(IN_FAULT, 8'h00, 8'hFF);
		poll(IN_STATUS, 8'h00, 8'h31);
		wr(OUT_ACTION, 8'h01);
		poll(IN_STATUS, {2'h0, STA_DONE, 4'h1}, 8'h31);
		wr(OUT_ACTION, 8'h31);
		poll(IN_FAULT, {4'h0, FLT_REL_BUSY}, 8'hFF);
		chk("rel_open", 8'h01, {7'h00, release_open});
		done("auto_release");
		complete_run();
	end
endmodule // gripper_command_status_registers_tb_top
`default_nettype wire
